// [src/usb_ctrl_core.sv]
`timescale 1ns/1ps
`include "usb_ctrl_regs.svh"
// Contract
// - keep running while cpu debug-halted
// - interrupt flags writable despite protection
// - debug halt lifts all write protection
// - external debugger writes never blocked
// - disabled after hardware reset
// - read-only state status at 0x0d
// - state field one-hot encodings
// - freeze lets ongoing transaction finish
// - freeze reads one after completion
// - frozen pipe issues no requests
// - current bank selects next packet bank
// - toggle cleared/set by clear/set writes
// - toggle inverts after each data transaction
// - toggle zero DATA0, one DATA1
// - setup done makes next DATA1
module usb_ctrl_core
   import usb_ctrl_pkg::*;
(
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic cpu_debug_halt,
   input wire logic ext_debug_access,
   input wire logic protect_lock,
   input wire logic xact_start,
   input wire logic xact_done,
   input wire logic xact_setup,
   input wire logic [6:0] link_state,
   output logic request_allowed,
   output logic data_pid_one,
   output logic bank_select,
   output logic usb_enable,
   output logic host_mode,
   output logic irq
);
   bus_req_s req;
   xact_s xact;
   logic enable;
   logic mode;
   logic [15:0] trim;
   logic protect_en;
   logic [6:0] state_field;
   logic halt_req;
   pipe_state_e pipe_state;
   logic toggle;
   logic bank;
   logic [`IRQ_WIDTH-1:0] flags;
   logic [`IRQ_WIDTH-1:0] mask;
   logic write_ok;
   logic wr_go;
   logic [31:0] wd;
   logic [31:0] next_rdata;
   logic state_legal;

   assign xact = '{start: xact_start, done: xact_done, setup: xact_setup};
   assign wr_go = req.valid && req.write;
   assign wd = hwdata;
   // state input legal only if exactly one bit set
   assign state_legal = $onehot(link_state);
   // protection lifted for debug halt or debugger access
   assign write_ok = !(protect_en && protect_lock) || cpu_debug_halt
      || ext_debug_access;

   // address phase capture; zero wait states so hreadyout stays high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req <= '0;
      end else if (hready) begin
         req.valid <= hsel && htrans[1];
         req.write <= hwrite;
         req.addr <= haddr[11:0];
      end else begin
         req.valid <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // control_a: enable and mode; no debug-halt freeze at all
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         enable <= 1'b0;
         mode <= 1'b0;
      end else if (wr_go && write_ok && req.addr == `CTRL_A_ADDR) begin
         enable <= wd[`CTRL_A_ENABLE_BIT];
         mode <= wd[`CTRL_A_MODE_BIT];
      end
   end

   // trim and protection enable
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         trim <= `TRIM_RESET;
         protect_en <= 1'b0;
      end else if (wr_go && write_ok) begin
         if (req.addr == `PAD_DRIVE_TRIM_ADDR) begin
            trim <= wd[15:0];
         end
         if (req.addr == `PROTECT_ADDR) begin
            protect_en <= wd[0];
         end
      end
   end

   // state machine status tracks the link while enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_field <= `STATE_OFF;
      end else if (!enable) begin
         state_field <= `STATE_OFF;
      end else if (state_legal) begin
         state_field <= link_state;
      end
   end

   // pipe freeze: busy pipe finishes before freeze shows
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         halt_req <= 1'b0;
         pipe_state <= pipe_idle;
      end else begin
         if (wr_go && write_ok && req.addr == `PIPE_CTRL_ADDR) begin
            halt_req <= wd[`PIPE_HALT_BIT];
         end
         case (pipe_state)
            pipe_idle: begin
               if (halt_req) begin
                  pipe_state <= pipe_frozen;
               end else if (xact.start && enable) begin
                  pipe_state <= pipe_busy;
               end
            end
            pipe_busy: begin
               if (xact.done) begin
                  pipe_state <= halt_req ? pipe_frozen : pipe_idle;
               end
            end
            pipe_frozen: begin
               if (!halt_req) begin
                  pipe_state <= pipe_idle;
               end
            end
            default: pipe_state <= pipe_idle;
         endcase
      end
   end

   // toggle and bank; hardware events win over writes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         toggle <= 1'b0;
         bank <= 1'b0;
      end else begin
         if (pipe_state == pipe_busy && xact.done) begin
            toggle <= xact.setup ? 1'b1 : !toggle;
            bank <= !bank;
         end else if (wr_go && write_ok) begin
            if (req.addr == `ENDPOINT_STATUS_CLEAR_ADDR && wd[`DATA_TOGGLE_BIT]) begin
               toggle <= 1'b0;
            end else if (req.addr == `ENDPOINT_STATUS_SET_ADDR && wd[`DATA_TOGGLE_BIT]) begin
               toggle <= 1'b1;
            end
         end
      end
   end

   // sticky flags: always writable, set wins over clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         flags <= '0;
         mask <= '0;
      end else begin
         for (int i = 0; i < `IRQ_WIDTH; i++) begin
            if (wr_go && req.addr == `INTERRUPT_FLAGS_ADDR && wd[i]) begin
               flags[i] <= 1'b0;
            end
         end
         if (pipe_state == pipe_busy && xact.done) begin
            flags[`IRQ_TRANS_DONE_BIT] <= 1'b1;
         end
         if (enable && state_legal && link_state != state_field) begin
            flags[`IRQ_STATE_CHANGE_BIT] <= 1'b1;
         end
         if (wr_go && write_ok && req.addr == `INTERRUPT_MASK_ADDR) begin
            mask <= wd[`IRQ_WIDTH-1:0];
         end
      end
   end

   // read mux, unmapped reads zero
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (haddr[11:0] & 12'hffc)
         `CTRL_A_ADDR: begin
            next_rdata[`CTRL_A_ENABLE_BIT] = enable;
            next_rdata[`CTRL_A_MODE_BIT] = mode;
         end
         `CONTROLLER_STATE_STATUS_ADDR: next_rdata[6:0] = state_field;
         `INTERRUPT_MASK_ADDR: next_rdata[`IRQ_WIDTH-1:0] = mask;
         `INTERRUPT_FLAGS_ADDR: next_rdata[`IRQ_WIDTH-1:0] = flags;
         `PAD_DRIVE_TRIM_ADDR: next_rdata[15:0] = trim;
         `PROTECT_ADDR: next_rdata[0] = protect_en;
         `PIPE_CTRL_ADDR: begin
            next_rdata[`PIPE_HALT_BIT] = halt_req;
            next_rdata[16+`PIPE_HALT_BIT] = pipe_state == pipe_frozen;
            next_rdata[16+`CURRENT_BANK_BIT] = bank;
            next_rdata[16+`DATA_TOGGLE_BIT] = toggle;
         end
         `PIPE_STATUS_ADDR: begin
            next_rdata[`PIPE_HALT_BIT] = pipe_state == pipe_frozen;
            next_rdata[`CURRENT_BANK_BIT] = bank;
            next_rdata[`DATA_TOGGLE_BIT] = toggle;
         end
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= 32'h0000_0000;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         hrdata <= next_rdata;
      end
   end

   // outputs registered
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         request_allowed <= 1'b0;
         data_pid_one <= 1'b0;
         bank_select <= 1'b0;
         usb_enable <= 1'b0;
         host_mode <= 1'b0;
         irq <= 1'b0;
      end else begin
         request_allowed <= enable && !halt_req && pipe_state == pipe_idle;
         data_pid_one <= toggle;
         bank_select <= bank;
         usb_enable <= enable;
         host_mode <= mode;
         irq <= |(flags & mask);
      end
   end

   property p_reset_off;
      @(posedge hclk) disable iff (!hresetn) !enable |-> ##1 state_field == `STATE_OFF;
   endproperty
   a_reset_off: assert property (p_reset_off) else $error("state not off");

   property p_onehot;
      @(posedge hclk) disable iff (!hresetn) $onehot(state_field);
   endproperty
   a_onehot: assert property (p_onehot) else $error("state not one-hot");

   property p_freeze_wait;
      @(posedge hclk) disable iff (!hresetn)
         pipe_state == pipe_busy && !xact.done |=> pipe_state != pipe_frozen;
   endproperty
   a_freeze_wait: assert property (p_freeze_wait) else $error("froze mid transaction");

   property p_finish;
      @(posedge hclk) disable iff (!hresetn)
         pipe_state == pipe_busy && xact.done && halt_req |=> pipe_state == pipe_frozen;
   endproperty
   a_finish: assert property (p_finish) else $error("no freeze after done");

   property p_no_req;
      @(posedge hclk) disable iff (!hresetn) pipe_state == pipe_frozen |=> !request_allowed;
   endproperty
   a_no_req: assert property (p_no_req) else $error("request while frozen");

   property p_toggle_flip;
      @(posedge hclk) disable iff (!hresetn)
         pipe_state == pipe_busy && xact.done && !xact.setup |=> toggle != $past(toggle);
   endproperty
   a_toggle_flip: assert property (p_toggle_flip) else $error("toggle not inverted");

   property p_pid;
      @(posedge hclk) disable iff (!hresetn) ##1 data_pid_one == $past(toggle);
   endproperty
   a_pid: assert property (p_pid) else $error("pid mismatch");

   property p_debug_write;
      @(posedge hclk) disable iff (!hresetn)
         wr_go && cpu_debug_halt && req.addr == `CTRL_A_ADDR |=> enable == $past(wd[1]);
   endproperty
   a_debug_write: assert property (p_debug_write) else $error("debug write blocked");

   property p_resume;
      @(posedge hclk) disable iff (!hresetn)
         pipe_state == pipe_frozen && !halt_req && enable |=> ##1 request_allowed;
   endproperty
   a_resume: assert property (p_resume) else $error("no resume");

   // write protection, debugger access and the always-writable flags
   property p_ext_write;
      @(posedge hclk) disable iff (!hresetn)
         wr_go && ext_debug_access && req.addr == `PAD_DRIVE_TRIM_ADDR
         |=> trim == $past(wd[15:0]);
   endproperty
   a_ext_write: assert property (p_ext_write) else $error("debugger write blocked");

   property p_locked_hold;
      @(posedge hclk) disable iff (!hresetn)
         wr_go && !write_ok && req.addr == `PAD_DRIVE_TRIM_ADDR |=> trim == $past(trim);
   endproperty
   a_locked_hold: assert property (p_locked_hold) else $error("locked write landed");

   property p_flag_clear;
      @(posedge hclk) disable iff (!hresetn)
         wr_go && req.addr == `INTERRUPT_FLAGS_ADDR && wd[`IRQ_STATE_CHANGE_BIT]
         && !(enable && state_legal && link_state != state_field)
         |=> !flags[`IRQ_STATE_CHANGE_BIT];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag clear refused");

   // state status follows legal link states; nothing requested while off
   property p_state_track;
      @(posedge hclk) disable iff (!hresetn)
         enable && state_legal |=> state_field == $past(link_state);
   endproperty
   a_state_track: assert property (p_state_track) else $error("state not tracked");

   property p_off_no_req;
      @(posedge hclk) disable iff (!hresetn) !enable |=> !request_allowed;
   endproperty
   a_off_no_req: assert property (p_off_no_req) else $error("request while disabled");

   // a cpu debug halt must not stall a transfer in flight
   property p_halt_runs;
      @(posedge hclk) disable iff (!hresetn)
         cpu_debug_halt && pipe_state == pipe_busy && xact.done |=> pipe_state != pipe_busy;
   endproperty
   a_halt_runs: assert property (p_halt_runs) else $error("halt stalled the pipe");

   // bank and toggle bookkeeping
   property p_bank_flip;
      @(posedge hclk) disable iff (!hresetn)
         pipe_state == pipe_busy && xact.done |=> bank != $past(bank);
   endproperty
   a_bank_flip: assert property (p_bank_flip) else $error("bank not swapped");

   property p_setup_toggle;
      @(posedge hclk) disable iff (!hresetn)
         pipe_state == pipe_busy && xact.done && xact.setup |=> toggle;
   endproperty
   a_setup_toggle: assert property (p_setup_toggle) else $error("setup toggle low");

   property p_toggle_set;
      @(posedge hclk) disable iff (!hresetn)
         wr_go && write_ok && req.addr == `ENDPOINT_STATUS_SET_ADDR && wd[`DATA_TOGGLE_BIT]
         && !(pipe_state == pipe_busy && xact.done) |=> toggle;
   endproperty
   a_toggle_set: assert property (p_toggle_set) else $error("set lost");

   property p_toggle_clear;
      @(posedge hclk) disable iff (!hresetn)
         wr_go && write_ok && req.addr == `ENDPOINT_STATUS_CLEAR_ADDR && wd[`DATA_TOGGLE_BIT]
         && !(pipe_state == pipe_busy && xact.done) |=> !toggle;
   endproperty
   a_toggle_clear: assert property (p_toggle_clear) else $error("clear lost");

   c_frozen: cover property (@(posedge hclk) pipe_state == pipe_frozen);
   c_done: cover property (@(posedge hclk) pipe_state == pipe_busy && xact.done);
   c_irq: cover property (@(posedge hclk) irq);
   c_setup: cover property (@(posedge hclk) pipe_state == pipe_busy && xact.done && xact.setup);
   c_debug_write: cover property (@(posedge hclk) wr_go && cpu_debug_halt && protect_lock);
endmodule : usb_ctrl_core

// [src/usb_ctrl_regs.svh]
`ifndef USB_CTRL_REGS_SVH
`define USB_CTRL_REGS_SVH
// byte addresses of the register words
`define CTRL_A_ADDR 12'h000
// state status is word index 0x0d; whole-word bus, so byte address is four times it
`define CONTROLLER_STATE_STATUS_INDEX 12'h00d
`define CONTROLLER_STATE_STATUS_ADDR 12'h034
`define PAD_DRIVE_TRIM_ADDR 12'h028
`define PROTECT_ADDR 12'h030
`define INTERRUPT_FLAGS_ADDR 12'h01c
`define INTERRUPT_MASK_ADDR 12'h018
`define PIPE_CTRL_ADDR 12'h100
`define ENDPOINT_STATUS_CLEAR_ADDR 12'h104
`define ENDPOINT_STATUS_SET_ADDR 12'h108
`define PIPE_STATUS_ADDR 12'h10c
// control_a fields
`define CTRL_A_ENABLE_BIT 1
`define CTRL_A_MODE_BIT 7
// pipe status fields
`define DATA_TOGGLE_BIT 0
`define CURRENT_BANK_BIT 2
`define PIPE_HALT_BIT 4
// controller state encodings, one-hot
`define STATE_OFF 7'h01
`define STATE_ON 7'h02
`define STATE_SUSPEND 7'h04
`define STATE_SLEEP 7'h08
`define STATE_DN_RESUME 7'h10
`define STATE_UP_RESUME 7'h20
`define STATE_BUS_RESET 7'h40
// interrupt flag bits
`define IRQ_TRANS_DONE_BIT 0
`define IRQ_STATE_CHANGE_BIT 1
`define IRQ_WIDTH 2
`define TRIM_RESET 16'h0000
`endif

// [src/usb_ctrl_pkg.sv]
package usb_ctrl_pkg;
   typedef enum logic [2:0] {
      pipe_idle = 3'b001,
      pipe_busy = 3'b010,
      pipe_frozen = 3'b100
   } pipe_state_e;
   typedef struct packed {
      logic [11:0] addr;
      logic write;
      logic valid;
   } bus_req_s;
   typedef struct packed {
      logic start;
      logic done;
      logic setup;
   } xact_s;
endpackage : usb_ctrl_pkg

// [tb/usb_link_model.sv]
`timescale 1ns/1ps
// far-side link: runs one transaction per go request, only when the pipe allows it
module usb_link_model (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic request_allowed,
   input wire logic go,
   input wire logic setup_kind,
   input wire logic [3:0] hold,
   input wire logic [6:0] state_cmd,
   output logic xact_start,
   output logic xact_done,
   output logic xact_setup,
   output logic [6:0] link_state,
   output logic busy,
   output logic finished
);
   logic armed;
   logic [3:0] cnt;
   // one start per go, so a held request cannot replay a transaction
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         {xact_start, xact_done, xact_setup, busy, finished, armed} <= '0;
         cnt <= '0;
         link_state <= 7'h01;
      end else begin
         xact_start <= 1'b0;
         xact_done <= 1'b0;
         finished <= xact_done;
         link_state <= state_cmd;
         if (!go) armed <= 1'b1;
         if (!busy && go && armed && request_allowed === 1'b1) begin
            busy <= 1'b1;
            armed <= 1'b0;
            xact_start <= 1'b1;
            xact_setup <= setup_kind; // level held through done
            cnt <= hold;
         end else if (busy) begin
            if (cnt == 4'h0) begin
               xact_done <= 1'b1;
               busy <= 1'b0;
            end else cnt <= cnt - 4'h1;
         end
      end
   end
endmodule : usb_link_model

// [tb/tb_usb_ctrl_core.sv]
`timescale 1ns/1ps
`include "usb_ctrl_regs.svh"
module tb_usb_ctrl_core;
   import usb_ctrl_pkg::*;
   logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rd_phase = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0] htrans = 0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, halt = 0, ext = 0, lock = 0, go = 0, su = 0;
   logic xs, xd, xsu, ra, pid1, bsel, en, hm, irq, busy, fin, tgl = 0, bank = 0;
   logic [6:0] ls, st = 7'h01;
   logic [3:0] len = 0;
   logic [15:0] trim;
   logic [31:0] exp_q[$], msk_q[$];
   int errors = 0, tests_run = 0, cyc = 0;
   usb_ctrl_core usb_ctrl_core_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_debug_halt(halt),
      .ext_debug_access(ext), .protect_lock(lock), .xact_start(xs), .xact_done(xd),
      .xact_setup(xsu), .link_state(ls), .request_allowed(ra), .data_pid_one(pid1),
      .bank_select(bsel), .usb_enable(en), .host_mode(hm), .irq(irq));
   usb_link_model usb_link_model_i (.hclk(hclk), .hresetn(hresetn), .request_allowed(ra),
      .go(go), .setup_kind(su), .hold(len), .state_cmd(st), .xact_start(xs), .xact_done(xd),
      .xact_setup(xsu), .link_state(ls), .busy(busy), .finished(fin));
   initial forever #2.5 hclk = ~hclk;
   task stop_test;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : stop_test
   // read results are judged here, against the oldest note
   task check_rd(input logic [31:0] d);
      logic [31:0] e, m;
      e = exp_q.pop_front();
      m = msk_q.pop_front();
      tests_run++;
      if ((d & m) !== e) begin
         errors++;
         $display("ERROR %0t read %h want %h", $time, d & m, e);
      end
   endtask : check_rd
   // cycle ceiling guards every wait; the whole run needs under a thousand
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         errors++;
         stop_test();
      end
      if (rd_phase && hreadyout === 1'b1) check_rd(hrdata);
   end
   // single word transfer, address held until hready, then data phase
   task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'b10;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      rd_phase <= !w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_phase <= 1'b0;
   endtask : ahb
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      exp_q.push_back(e);
      msk_q.push_back(m);
      ahb(1'b0, a, 32'h0);
   endtask : rd
   // level outputs sampled mid-cycle, away from the launching edge
   task automatic chk(ref logic got, input logic want, input int n);
      repeat (n) @(negedge hclk);
      tests_run++;
      if (got !== want) begin
         errors++;
         $display("ERROR %0t output %b want %b", $time, got, want);
      end
      @(posedge hclk);
   endtask : chk
   task automatic pipe(input logic f);
      rd(`PIPE_CTRL_ADDR, (32'(f) << 20) | (32'(bank) << 18) | (32'(tgl) << 16), 32'h00150000);
   endtask : pipe
   task automatic wait_fin;
      for (int i = 0; i < 60 && fin !== 1'b1; i++) @(posedge hclk);
      go <= 1'b0;
      if (fin !== 1'b1) begin
         errors++;
         $display("ERROR %0t transfer never finished", $time);
      end
   endtask : wait_fin
   initial begin
      void'($urandom(34182));
      trim = 16'($urandom);
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(en, 1'b0, 1);
      chk(hreadyout, 1'b1, 1);
      chk(hresp, 1'b0, 1);
      chk(ra, 1'b0, 1);
      rd(`CONTROLLER_STATE_STATUS_ADDR, 32'h01, 32'hff);
      ahb(1'b1, `CONTROLLER_STATE_STATUS_ADDR, 32'h7e);
      rd(`CONTROLLER_STATE_STATUS_ADDR, 32'h01, 32'hff);
      $display("test reset done");
      ahb(1'b1, `PAD_DRIVE_TRIM_ADDR, {16'h0, trim});
      rd(`PAD_DRIVE_TRIM_ADDR, {16'h0, trim}, 32'hffff);
      ahb(1'b1, `CTRL_A_ADDR, 32'h82);
      chk(en, 1'b1, 2);
      chk(hm, 1'b1, 1);
      for (int i = 0; i < 8; i++) begin
         st <= (i == 7) ? 7'h03 : 7'h01 << i; // last code is reserved and ignored
         repeat (4) @(posedge hclk);
         rd(`CONTROLLER_STATE_STATUS_ADDR, 32'h01 << (i == 7 ? 6 : i), 32'hff);
      end
      $display("test states done");
      ahb(1'b1, `INTERRUPT_MASK_ADDR, 32'h2);
      chk(irq, 1'b1, 2);
      ahb(1'b1, `INTERRUPT_MASK_ADDR, 32'h0);
      chk(irq, 1'b0, 2);
      ahb(1'b1, `INTERRUPT_MASK_ADDR, 32'h3);
      ahb(1'b1, `PROTECT_ADDR, 32'h1);
      lock <= 1'b1;
      ahb(1'b1, `PAD_DRIVE_TRIM_ADDR, {16'h0, ~trim});
      rd(`PAD_DRIVE_TRIM_ADDR, {16'h0, trim}, 32'hffff);
      ahb(1'b1, `INTERRUPT_FLAGS_ADDR, 32'h3);
      chk(irq, 1'b0, 2);
      rd(`INTERRUPT_FLAGS_ADDR, 32'h0, 32'h3);
      halt <= 1'b1;
      ahb(1'b1, `PAD_DRIVE_TRIM_ADDR, {16'h0, ~trim});
      rd(`PAD_DRIVE_TRIM_ADDR, {16'h0, ~trim}, 32'hffff);
      ahb(1'b1, `CTRL_A_ADDR, 32'h80);
      chk(en, 1'b0, 2);
      ahb(1'b1, `CTRL_A_ADDR, 32'h82);
      chk(en, 1'b1, 2);
      halt <= 1'b0;
      ext <= 1'b1;
      ahb(1'b1, `PAD_DRIVE_TRIM_ADDR, {16'h0, trim});
      ext <= 1'b0;
      rd(`PAD_DRIVE_TRIM_ADDR, {16'h0, trim}, 32'hffff);
      lock <= 1'b0;
      $display("test protect done");
      ahb(1'b1, `ENDPOINT_STATUS_SET_ADDR, 32'h1);
      tgl = 1'b1;
      chk(pid1, 1'b1, 2);
      ahb(1'b1, `ENDPOINT_STATUS_CLEAR_ADDR, 32'h1);
      tgl = 1'b0;
      chk(pid1, 1'b0, 2);
      pipe(1'b0);
      halt <= 1'b1; // transfers carry on while the cpu is halted
      for (int i = 0; i < 6; i++) begin
         su <= (i == 2) || ($urandom_range(0, 3) == 0);
         len <= 4'($urandom_range(0, 8));
         go <= 1'b1;
         @(posedge hclk);
         wait_fin();
         tgl = su ? 1'b1 : !tgl;
         bank = !bank;
         pipe(1'b0);
         chk(pid1, tgl, 1);
         chk(bsel, bank, 1);
      end
      halt <= 1'b0;
      chk(irq, 1'b1, 2);
      $display("test toggle done");
      su <= 1'b0;
      len <= 4'hc;
      go <= 1'b1;
      for (int i = 0; i < 20 && busy !== 1'b1; i++) @(posedge hclk);
      if (busy !== 1'b1) begin
         errors++;
         $display("ERROR %0t transfer never started", $time);
      end
      ahb(1'b1, `PIPE_CTRL_ADDR, 32'h10);
      pipe(1'b0);
      wait_fin();
      tgl = !tgl;
      bank = !bank;
      pipe(1'b1);
      rd(`PIPE_STATUS_ADDR, 32'h10 | (32'(bank) << 2) | 32'(tgl), 32'h15);
      chk(ra, 1'b0, 1);
      go <= 1'b1;
      repeat (10) @(posedge hclk);
      chk(ra, 1'b0, 1);
      ahb(1'b1, `PIPE_CTRL_ADDR, 32'h0);
      chk(ra, 1'b1, 3);
      wait_fin();
      tgl = !tgl;
      bank = !bank;
      pipe(1'b0);
      $display("test freeze done");
      stop_test();
   end
endmodule : tb_usb_ctrl_core
